// *** mps_page_select.sv ***
// memory board page selection with its control register
`timescale 1ns/100ps
module mps_page_select (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [17:0] regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  input  wire logic [21:0] memAddr,
  input  wire logic        memReqN,
  input  wire logic [3:0]  boardSelN,
  input  wire logic [3:0]  pageStrap,
  input  wire logic [3:0]  csrSelStrap,
  input  wire logic [1:0]  optStrap,
  input  wire logic        supAddrEnStrap,
  input  wire logic        commonLoStrap,
  input  wire logic        commonHiStrap,
  input  wire logic        parErrEvt,
  output logic             memSelect,
  output logic             wrongParity,
  output logic             parityEnable
);

  localparam int PIN_W = 22 + 1 + 4 + 4 + 4 + 2 + 1 + 1 + 1;

  // memory bus pins and straps pass two flops before decode; register port and parErrEvt levels are used directly
  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinSync;
  logic [21:0]      addrS;
  logic             reqS;
  logic [3:0]       boardSelS;
  logic [3:0]       pageStrapS;
  logic [3:0]       csrSelS;
  logic [1:0]       optS;
  logic             supEnS;
  logic             commonLoS;
  logic             commonHiS;

  assign pinRaw = {memAddr, ~memReqN, boardSelN, pageStrap, csrSelStrap,
                   optStrap, supAddrEnStrap, commonLoStrap, commonHiStrap};

  mps_sync #(
    .WIDTH (PIN_W)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   (pinRaw),
    .syncOut (pinSync)
  );

  assign {addrS, reqS, boardSelS, pageStrapS, csrSelS,
          optS, supEnS, commonLoS, commonHiS} = pinSync;

  // page match decode
  mps_match_if mIf ();

  logic [3:0] pageReg_reg;
  logic [3:0] pageReg_next;

  assign mIf.addr       = addrS;
  assign mIf.boardSelN  = boardSelS;
  assign mIf.pageReg    = pageReg_reg;
  assign mIf.pageStrap  = pageStrapS;
  assign mIf.supEn      = supEnS;
  assign mIf.commonLoEn = commonLoS;
  assign mIf.commonHiEn = commonHiS;
  assign mIf.opt        = mps_pkg::mps_opt_t'(optS);

  mps_page_match u_match (
    .m (mIf)
  );

  // register port decode
  logic [17:0] csrAddr;
  logic        csrHit;
  logic        csrWr;
  logic        csrRd;

  always_comb begin
    csrAddr = mps_pkg::CSR_BASE_ADDR +
              18'({csrSelS, 1'b0});
    csrHit  = (regAddr == csrAddr);
    // no byte lanes exist on this port, so every access is a word
    csrWr   = regWr && csrHit;
    csrRd   = regRd && csrHit;
  end

  // control register state
  logic       perr_reg;
  logic       perr_next;
  logic       rdSel_reg;
  logic       rdSel_next;
  logic [6:0] field_reg;
  logic [6:0] field_next;
  logic [3:0] capSel_reg;
  logic [3:0] capSel_next;
  logic       wwp_reg;
  logic       wwp_next;
  logic       pen_reg;
  logic       pen_next;

  always_comb begin
    perr_next    = perr_reg;
    rdSel_next   = rdSel_reg;
    field_next   = field_reg;
    capSel_next  = capSel_reg;
    wwp_next     = wwp_reg;
    pen_next     = pen_reg;
    pageReg_next = pageReg_reg;
    if (csrWr) begin
      perr_next  = regWrData[mps_pkg::PERR_BIT];
      rdSel_next = regWrData[mps_pkg::RDSEL_BIT];
      field_next = regWrData[mps_pkg::FIELD_HI:mps_pkg::FIELD_LO];
      wwp_next   = regWrData[mps_pkg::WWP_BIT];
      pen_next   = regWrData[mps_pkg::PEN_BIT];
      // page only moves on a write that also carries bit 13
      if (regWrData[mps_pkg::PGWE_BIT]) begin
        pageReg_next = regWrData[mps_pkg::PAGE_HI:mps_pkg::PAGE_LO];
      end
    end
    // error capture wins over a write in the same cycle
    if (parErrEvt) begin
      perr_next   = 1'b1;
      field_next  = addrS[17:11];
      capSel_next = mIf.selVal;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      perr_reg    <= mps_pkg::BIT_RST;
      rdSel_reg   <= mps_pkg::BIT_RST;
      field_reg   <= mps_pkg::FIELD_RST;
      capSel_reg  <= mps_pkg::PAGE_RST;
      wwp_reg     <= mps_pkg::BIT_RST;
      pen_reg     <= mps_pkg::BIT_RST;
      pageReg_reg <= mps_pkg::PAGE_RST;
    end else begin
      perr_reg    <= perr_next;
      rdSel_reg   <= rdSel_next;
      field_reg   <= field_next;
      capSel_reg  <= capSel_next;
      wwp_reg     <= wwp_next;
      pen_reg     <= pen_next;
      pageReg_reg <= pageReg_next;
    end
  end

  // read data, valid only in the cycle after the strobe
  logic [15:0] rdWord;
  logic [15:0] rdData_reg;
  logic [15:0] rdData_next;
  logic [3:0]  pageView;

  always_comb begin
    rdWord = mps_pkg::RD_IDLE;
    rdWord[mps_pkg::PERR_BIT]  = perr_reg;
    rdWord[mps_pkg::RDSEL_BIT] = rdSel_reg;
    rdWord[mps_pkg::FIELD_HI:mps_pkg::FIELD_LO] = field_reg;
    // bits 13, 12, 4, 3 and 1 stay zero from RD_IDLE
    rdWord[mps_pkg::WWP_BIT]   = wwp_reg;
    rdWord[mps_pkg::PEN_BIT]   = pen_reg;
    pageView = perr_reg ? capSel_reg : pageReg_reg;
    if (rdSel_reg) begin
      rdWord[mps_pkg::PAGE_HI:mps_pkg::PAGE_LO] = pageView;
    end
    rdData_next = csrRd ? rdWord : mps_pkg::RD_IDLE;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdData_reg <= mps_pkg::RD_IDLE;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData    = rdData_reg;
  assign wrongParity  = wwp_reg;
  assign parityEnable = pen_reg;

  // memory cycle: decision taken once at request and held
  mps_pkg::mps_state_t state_reg;
  mps_pkg::mps_state_t state_next;
  logic                sel_reg;
  logic                sel_next;

  always_comb begin
    state_next = state_reg;
    sel_next   = sel_reg;
    case (state_reg)
      mps_pkg::ST_IDLE: begin
        if (reqS) begin
          // select lines must already be valid here
          state_next = mps_pkg::ST_CYCLE;
          sel_next   = mIf.hit;
        end
      end
      mps_pkg::ST_CYCLE: begin
        if (!reqS) begin
          state_next = mps_pkg::ST_IDLE;
          sel_next   = 1'b0;
        end
      end
      default: begin
        state_next = mps_pkg::ST_IDLE;
        sel_next   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= mps_pkg::ST_IDLE;
      sel_reg   <= mps_pkg::BIT_RST;
    end else begin
      state_reg <= state_next;
      sel_reg   <= sel_next;
    end
  end

  assign memSelect = sel_reg;

endmodule // mps_page_select

// *** mps_pkg.sv ***
// constants and types shared by the memory page select block
package mps_pkg;

  // control register decode: base word, 16 strap-selected word slots
  localparam logic [17:0] CSR_BASE_ADDR  = 18'h3f440;
  localparam int          CSR_SEL_W      = 4;
  localparam int          CSR_SLOT_SHIFT = 1;

  // control register field positions
  localparam int PERR_BIT    = 15;
  localparam int RDSEL_BIT   = 14;
  localparam int PGWE_BIT    = 13;
  localparam int FIELD_HI    = 11;
  localparam int FIELD_LO    = 5;
  localparam int PAGE_HI     = 8;
  localparam int PAGE_LO     = 5;
  localparam int WWP_BIT     = 2;
  localparam int PEN_BIT     = 0;

  // reset values
  localparam logic [6:0]  FIELD_RST = 7'h00;
  localparam logic [3:0]  PAGE_RST  = 4'h0;
  localparam logic        BIT_RST   = 1'h0;
  localparam logic [15:0] RD_IDLE   = 16'h0000;

  // address regions, in byte address bits
  localparam int          ADDR_W      = 22;
  localparam int          PAGE_W      = 4;
  localparam logic [8:0]  IO_PAGE_HI  = 9'h1ff;
  localparam logic [4:0]  COMMON_TOP  = 5'h1f;
  localparam logic [4:0]  COMMON_BOT  = 5'h00;

  typedef enum logic [1:0] {
    OPT_DIRECT,
    OPT_EXTERNAL,
    OPT_REGISTER,
    OPT_NONE
  } mps_opt_t;

  typedef enum logic {
    ST_IDLE,
    ST_CYCLE
  } mps_state_t;

endpackage

// *** mps_match_if.sv ***
// carrier between the top and the page match decoder
`timescale 1ns/100ps
interface mps_match_if;
  logic [mps_pkg::ADDR_W-1:0] addr;
  logic [mps_pkg::PAGE_W-1:0] boardSelN;
  logic [mps_pkg::PAGE_W-1:0] pageReg;
  logic [mps_pkg::PAGE_W-1:0] pageStrap;
  logic                       supEn;
  logic                       commonLoEn;
  logic                       commonHiEn;
  mps_pkg::mps_opt_t          opt;
  logic [mps_pkg::PAGE_W-1:0] selVal;
  logic                       hit;

  modport top (output addr, boardSelN, pageReg, pageStrap, supEn, commonLoEn,
               commonHiEn, opt, input selVal, hit);
  modport match (input addr, boardSelN, pageReg, pageStrap, supEn, commonLoEn,
                 commonHiEn, opt, output selVal, hit);
endinterface

// *** mps_sync.sv ***
// two-stage synchroniser for a vector of pin levels
`timescale 1ns/100ps
module mps_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage1_next;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage2_next;

  if (WIDTH < 1) begin : g_chk
    $error("mps_sync: WIDTH must be at least 1");
  end

  always_comb begin
    stage1_next = pinIn;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign syncOut = stage2_reg;
endmodule // mps_sync

// *** mps_page_match.sv ***
// decides whether a memory cycle belongs to this board
`timescale 1ns/100ps
module mps_page_match (
  mps_match_if.match m
);
  logic ioRegion;
  logic commonHit;

  always_comb begin
    // direct option: top 4K words of the 22-bit space is the I/O page
    ioRegion  = (m.addr[21:13] == mps_pkg::IO_PAGE_HI);
    commonHit = (m.commonLoEn && (m.addr[17:13] == mps_pkg::COMMON_BOT)) ||
                (m.commonHiEn && (m.addr[17:13] == mps_pkg::COMMON_TOP));
    case (m.opt)
      mps_pkg::OPT_DIRECT:   m.selVal = m.addr[21:18];
      mps_pkg::OPT_EXTERNAL: m.selVal = ~m.boardSelN;
      mps_pkg::OPT_REGISTER: m.selVal = m.pageReg;
      default:               m.selVal = ~m.boardSelN;
    endcase
    if (!m.supEn) begin
      // unpaged: plain 18-bit memory below its own I/O page
      m.hit = (m.addr[17:13] != mps_pkg::COMMON_TOP);
    end else if (m.opt == mps_pkg::OPT_DIRECT && ioRegion) begin
      m.hit = 1'b0;
    end else if (m.opt == mps_pkg::OPT_NONE) begin
      m.hit = 1'b0;
    end else begin
      // strap is an active-high binary page number
      m.hit = (m.selVal == m.pageStrap) || commonHit;
    end
  end
endmodule // mps_page_match

// *** mps_page_select_sva.sv ***
// assertion checker for the memory page select top
`timescale 1ns/100ps
module mps_page_select_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [17:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic        memReqN,
  input wire logic [3:0]  csrSelStrap,
  input wire logic        memSelect,
  input wire logic        wrongParity,
  input wire logic        parityEnable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [17:0] csrAddr;
  assign csrAddr = mps_pkg::CSR_BASE_ADDR + {13'h0, csrSelStrap, 1'b0};

  a_resv_zero: assert property ((regRdData & 16'h301a) == 16'h0000)
    else $error("reserved control bits read nonzero");
  a_rd_one_cycle: assert property (regRdData != 16'h0000 |-> $past(regRd))
    else $error("read data outside its cycle");
  a_unmapped_rd: assert property ($past(regRd) && $past(regAddr) != $past(csrAddr) |-> regRdData == 16'h0000)
    else $error("unmapped read returned data");
  a_ctl_write: assert property (regWr && regAddr == csrAddr
    |=> wrongParity == $past(regWrData[2]) && parityEnable == $past(regWrData[0]))
    else $error("control bits not taken from write");
  a_no_req_quiet: assert property (memReqN [*4] |-> !memSelect)
    else $error("select without a request");
  a_sel_after_req: assert property ($rose(memSelect) |-> !$past(memReqN, 2))
    else $error("select rose too early");
  a_sel_release: assert property ($rose(memReqN) |-> ##[1:4] !memSelect)
    else $error("select not dropped after request");
  a_sel_hold: assert property ($fell(memSelect) |-> $past(memReqN, 2))
    else $error("select dropped inside a request");

  cover property ($rose(memSelect));
  cover property ($past(regRd) && regRdData[15]);
  cover property (regWr && regWrData[13]);
endmodule // mps_page_select_chk

bind mps_page_select mps_page_select_chk mps_page_select_chk_inst (.sys_clk, .rst_n, .regAddr, .regWrData,
  .regWr, .regRd, .regRdData, .memReqN, .csrSelStrap, .memSelect, .wrongParity, .parityEnable);

// *** mps_far_master.sv ***
// far-side bus master and page-select driver model
`timescale 1ns/100ps
module mps_far_master (
  input  wire logic        sys_clk,
  input  wire logic        memSelect,
  output logic      [21:0] memAddr,
  output logic             memReqN,
  output logic      [3:0]  boardSelN,
  output logic             hitSeen
);
  initial begin
    memAddr = 22'h000000;
    memReqN = 1'b1;
    boardSelN = 4'hf;
    hitSeen = 1'b0;
  end
  // selects stay latched after the cycle, as a latching driver would
  task automatic cycle(input logic [21:0] a, input logic [3:0] p);
    @(posedge sys_clk);
    memAddr <= a;
    // page chosen before the request so every transfer lands where meant
    boardSelN <= ~p;
    hitSeen <= 1'b0;
    repeat (3) @(posedge sys_clk);
    memReqN <= 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      if (memSelect) hitSeen <= 1'b1;
    end
    memReqN <= 1'b1;
    repeat (4) @(posedge sys_clk);
    memAddr <= ~a; // released lines must not keep the old value
  endtask
endmodule // mps_far_master

// *** memory_page_select_bench.sv ***
// self-checking bench for the memory page select block
`timescale 1ns/100ps
module memory_page_select_bench;
  logic        sys_clk, rst_n, regWr, regRd, memReqN, memSelect, hitSeen, parErrEvt;
  logic        supAddrEnStrap, commonLoStrap, commonHiStrap;
  logic        wrongParity, parityEnable;
  logic        rdPend = 1'b0;
  logic        reqPrev = 1'b1;
  logic [17:0] regAddr, csr;
  logic [15:0] regWrData, regRdData, w;
  logic [21:0] memAddr;
  logic [3:0]  boardSelN, pageStrap, csrSelStrap, pg;
  logic [1:0]  optStrap;
  logic [15:0] expQ[$];
  int          errors = 0;
  int          n_checks = 0;
  int          cyc = 0;

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  mps_page_select mps_page_select_inst (.sys_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .memAddr, .memReqN, .boardSelN, .pageStrap, .csrSelStrap, .optStrap, .supAddrEnStrap, .commonLoStrap,
    .commonHiStrap, .parErrEvt, .memSelect, .wrongParity, .parityEnable);
  mps_far_master mps_far_master_inst (.sys_clk, .memSelect, .memAddr, .memReqN, .boardSelN, .hitSeen);

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    @(posedge sys_clk);
    regRd <= 1'b0;
  endtask

  task automatic mem(input logic [21:0] a, input logic [3:0] p, input logic e);
    expQ.push_back({15'h0, e});
    mps_far_master_inst.cycle(a, p);
  endtask

  // results are paired with the oldest expectation in issue order
  always @(posedge sys_clk) begin
    rdPend <= regRd;
    reqPrev <= memReqN;
    if (rdPend && expQ.size() > 0) cmp("regRdData", regRdData, expQ.pop_front());
    if (memReqN && !reqPrev && expQ.size() > 0) cmp("memSelect", {15'h0, hitSeen}, expQ.pop_front());
    cyc++;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    w = 16'($urandom(32'hb67e)) & 16'h3fff;
    pg = 4'($urandom);
    csrSelStrap = 4'($urandom);
    csr = mps_pkg::CSR_BASE_ADDR + {13'h0, csrSelStrap, 1'b0};
    {rst_n, regWr, regRd, parErrEvt, commonLoStrap, commonHiStrap} = 6'h00;
    regAddr = 18'h00000;
    regWrData = 16'h0000;
    pageStrap = pg;
    optStrap = 2'h2;
    supAddrEnStrap = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // straps reach the address decode only after the two synchroniser flops
    repeat (2) @(posedge sys_clk);
    rd(csr, 16'h0000);
    wr(csr, w);
    @(posedge sys_clk);
    cmp("wrongParity", {15'h0, wrongParity}, {15'h0, w[2]});
    cmp("parityEnable", {15'h0, parityEnable}, {15'h0, w[0]});
    wr(csr ^ 18'h00020, 16'hffff);
    rd(csr ^ 18'h00020, 16'h0000);
    rd(csr, w & 16'h0fe5);
    wr(csr, 16'h2000 | {7'h0, pg, 5'h0});
    wr(csr, 16'h4000 | {7'h0, ~pg, 5'h0});
    rd(csr, 16'h4000 | {7'h0, pg, 5'h0});
    wr(csr, 16'h0000);
    rd(csr, 16'h0000);
    mem(22'h004000, pg, 1'b1);
    wr(csr, 16'h2000 | {7'h0, ~pg, 5'h0});
    mem(22'h004000, pg, 1'b0);
    commonLoStrap <= 1'b1;
    mem(22'h000100, pg, 1'b1);
    commonLoStrap <= 1'b0;
    commonHiStrap <= 1'b1;
    mem(22'h03e100, pg, 1'b1);
    commonHiStrap <= 1'b0;
    optStrap <= 2'h1;
    mem(22'h004000, pg, 1'b1);
    mem(22'h004000, ~pg, 1'b0);
    optStrap <= 2'h0;
    mem({pg, 18'h04000}, ~pg, 1'b1);
    mem({~pg, 18'h04000}, pg, 1'b0);
    pageStrap <= 4'hf;
    mem(22'h3fe000, 4'h0, 1'b0);
    pageStrap <= pg;
    supAddrEnStrap <= 1'b0;
    mem({~pg, 18'h04000}, ~pg, 1'b1);
    supAddrEnStrap <= 1'b1;
    optStrap <= 2'h3;
    mem({pg, 18'h04000}, pg, 1'b0);
    optStrap <= 2'h1;
    mem(22'h000000, pg, 1'b1);
    wr(csr, 16'h4000);
    @(posedge sys_clk);
    parErrEvt <= 1'b1;
    @(posedge sys_clk);
    parErrEvt <= 1'b0;
    rd(csr, 16'hce00 | {7'h0, pg, 5'h0});
    repeat (4) @(posedge sys_clk);
    if (expQ.size() != 0) errors++;
    conclude();
  end
endmodule // memory_page_select_bench
